/* File: logic/sram_host_cfg.svh */
`ifndef SRAM_HOST_CFG_SVH
`define SRAM_HOST_CFG_SVH

// ==========================================================
// timing figures in ns, clock period in ns
`define CLK_PERIOD_NS        40
`define ADDR_SETUP_NS        15
`define WRITE_OVERLAP_NS     70
`define DATA_SETUP_NS        50
`define DATA_HOLD_NS         5
`define WRITE_RECOVERY_NS    15
`define FLOAT_AFTER_WRITE_NS 50
`define READ_CYCLE_NS        120
`define GATE_TO_VALID_NS     80
`define FLOAT_AFTER_DESEL_NS 50

// ==========================================================
// all times but data setup and gate-to-valid round up to whole cycles (min one cycle)
`define CYC_UP(ns)   (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ADDR_SETUP_CYC     `CYC_UP(`ADDR_SETUP_NS)
`define WRITE_OVERLAP_CYC  `CYC_UP(`WRITE_OVERLAP_NS)
`define DATA_HOLD_CYC      `CYC_UP(`DATA_HOLD_NS)
`define WRITE_RECOVERY_CYC `CYC_UP(`WRITE_RECOVERY_NS)
`define FLOAT_WRITE_CYC    `CYC_UP(`FLOAT_AFTER_WRITE_NS)
`define READ_CYCLE_CYC     `CYC_UP(`READ_CYCLE_NS)
`define FLOAT_DESEL_CYC    `CYC_UP(`FLOAT_AFTER_DESEL_NS)
`define CNT_ZERO           4'h0
`define ADDR_RESET         11'h000
`define DATA_RESET         8'h00

`endif

/* File: logic/sram_host_pkg.sv */
package sram_host_pkg;
    // ======================================================
    // sequencer states, gray codes along the write path only
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_SETUP  = 3'b001,
        ST_STROBE = 3'b011,
        ST_HOLD   = 3'b010,
        ST_RSAMP  = 3'b110,
        ST_FLOAT  = 3'b111
    } seq_state_t;
endpackage : sram_host_pkg

/* File: logic/sync2.sv */
`timescale 1ns/10ps
// ==========================================================
// two-flop synchroniser for pin inputs
module sync2 #(
    parameter int W = 8
) (
    // clock and reset
    input  wire logic         ref_clk,
    input  wire logic         srst,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // first flop feeds only the second
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule : sync2

/* File: logic/sram_host.sv */
`timescale 1ns/10ps
`include "sram_host_cfg.svh"
module sram_host #(
    parameter int AW = 11,
    parameter int DW = 8
) (
    // clock and reset
    input  wire logic          ref_clk,
    input  wire logic          srst,
    // user request
    input  wire logic          req_valid,
    input  wire logic          req_write,
    input  wire logic [AW-1:0] req_addr,
    input  wire logic [DW-1:0] req_wdata,
    output logic               req_ready,
    output logic               rd_valid,
    output logic      [DW-1:0] rd_data,
    // memory pins
    output logic      [AW-1:0] mem_addr,
    output logic               mem_cs_n,
    output logic               mem_we_n,
    output logic               mem_oe_n,
    output logic      [DW-1:0] mem_dq_o,
    output logic               mem_dq_oe,
    input  wire logic [DW-1:0] mem_dq_i
);
    import sram_host_pkg::*;

    // ======================================================
    // state
    seq_state_t  state_reg;
    logic [3:0]  cnt_reg;
    logic        wr_reg;
    logic [DW-1:0] dq_sync;
    logic [3:0]    quiet_cnt_reg;
    logic          take;
    logic          bus_quiet;
    logic          setup_done;

    // count loaded with a cycle figure minus one
    function automatic logic [3:0] load_cnt(input int cyc);
        load_cnt = (cyc > 1) ? 4'(cyc - 1) : `CNT_ZERO;
    endfunction : load_cnt

    wire cnt_done = (cnt_reg == `CNT_ZERO);

    // a request is taken only from idle
    function automatic logic is_take(input seq_state_t st, input logic valid);
        is_take = (st == ST_IDLE) && valid;
    endfunction : is_take

    // ======================================================
    // decoded strobes shared by the pin processes
    assign take       = is_take(state_reg, req_valid);
    assign bus_quiet  = (quiet_cnt_reg == `CNT_ZERO);
    // a write waits in setup until the memory is known to float
    assign setup_done = cnt_done && (bus_quiet || !wr_reg);

    // ======================================================
    // bus-turn guard, counts down after the memory could last drive
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            quiet_cnt_reg <= `CNT_ZERO;
        end else if (!mem_cs_n && !mem_oe_n) begin
            quiet_cnt_reg <= 4'(`FLOAT_DESEL_CYC);
        end else if (!bus_quiet) begin
            quiet_cnt_reg <= quiet_cnt_reg - 4'h1;
        end
    end

    // ======================================================
    // data pin input synchroniser
    sync2 #(.W(DW)) u_dq_sync (
        .ref_clk (ref_clk),
        .srst    (srst),
        .d       (mem_dq_i),
        .q       (dq_sync)
    );

    // ======================================================
    // sequencer and counter
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= `CNT_ZERO;
            wr_reg    <= 1'b0;
        end else begin
            if (!cnt_done) cnt_reg <= cnt_reg - 4'h1;
            unique case (state_reg)
                ST_IDLE: begin
                    if (req_valid) begin
                        wr_reg    <= req_write;
                        state_reg <= ST_SETUP;
                        cnt_reg   <= load_cnt(`ADDR_SETUP_CYC);
                    end
                end
                ST_SETUP: begin
                    // address settles; a write also waits for quiet pins
                    if (setup_done) begin
                        state_reg <= ST_STROBE;
                        cnt_reg   <= wr_reg ? load_cnt(`WRITE_OVERLAP_CYC)
                                            : load_cnt(`READ_CYCLE_CYC);
                    end
                end
                ST_STROBE: begin
                    // overlap or read cycle runs out
                    if (cnt_done) begin
                        state_reg <= wr_reg ? ST_HOLD : ST_RSAMP;
                        cnt_reg   <= load_cnt(`WRITE_RECOVERY_CYC);
                    end
                end
                ST_HOLD: begin
                    // data still driven for the hold time
                    if (cnt_done) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_RSAMP: begin
                    // wait one cycle for the sampled byte to reach the second synchroniser stage
                    if (cnt_done) begin
                        state_reg <= ST_FLOAT;
                        cnt_reg   <= load_cnt(`FLOAT_DESEL_CYC);
                    end
                end
                ST_FLOAT: begin
                    // memory lets go of the pins before the next take
                    if (cnt_done) begin
                        state_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // ======================================================
    // address and strobe pins, all registered
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mem_addr  <= `ADDR_RESET;
            mem_cs_n  <= 1'b1;
            mem_we_n  <= 1'b1;
            mem_oe_n  <= 1'b1;
        end else begin
            if (take) begin
                mem_addr <= req_addr;
                mem_cs_n <= 1'b0;
                mem_oe_n <= 1'b1;
                mem_we_n <= 1'b1;
            end
            if (state_reg == ST_SETUP && setup_done) begin
                mem_we_n <= !wr_reg;
                mem_oe_n <= wr_reg;
            end
            if (state_reg == ST_STROBE && cnt_done) begin
                mem_we_n <= 1'b1;
                mem_cs_n <= 1'b1;
                mem_oe_n <= 1'b1;
            end
        end
    end

    // ======================================================
    // acceptance pulse, raised at the taking edge for one cycle
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            req_ready <= 1'b0;
        end else begin
            req_ready <= take;
        end
    end

    // ======================================================
    // write data drive, opened only after any read drive has floated
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mem_dq_o  <= `DATA_RESET;
            mem_dq_oe <= 1'b0;
        end else begin
            if (take && req_write) begin
                mem_dq_o <= req_wdata;
            end
            // setup spans a float interval after the last read ended
            if (state_reg == ST_SETUP && wr_reg && bus_quiet) begin
                mem_dq_oe <= 1'b1;
            end
            // hold one cycle past strobe rise
            if (state_reg == ST_HOLD && cnt_done) begin
                mem_dq_oe <= 1'b0;
            end
        end
    end

    // ======================================================
    // read data capture
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rd_data  <= `DATA_RESET;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= 1'b0;
            // first float cycle: byte sampled at strobe rise leaves the sync
            if (state_reg == ST_FLOAT && cnt_reg == load_cnt(`FLOAT_DESEL_CYC)) begin
                rd_data  <= dq_sync;
                rd_valid <= 1'b1;
            end
        end
    end
endmodule : sram_host

/* File: bench/sram_host_assertions.sv */
`timescale 1ns/10ps
// ==========================================================
// pin ordering checks for the host sequencer
module sram_host_checker #(
    parameter int AW = 11
) (
    // clock and reset
    input wire logic          ref_clk,
    input wire logic          srst,
    // user side
    input wire logic          req_valid,
    input wire logic          req_ready,
    input wire logic          rd_valid,
    // memory pins
    input wire logic [AW-1:0] mem_addr,
    input wire logic          mem_cs_n,
    input wire logic          mem_we_n,
    input wire logic          mem_oe_n,
    input wire logic          mem_dq_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    standby_quiet_a: assert property (mem_cs_n |-> mem_we_n && mem_oe_n)
        else $error("strobe low while deselected");
    we_in_cs_a: assert property (!mem_we_n |-> !mem_cs_n)
        else $error("write strobe outside select");
    gate_off_write_a: assert property (!mem_we_n |-> mem_oe_n)
        else $error("output gate low during write");
    addr_setup_a: assert property ($fell(mem_we_n) |-> $stable(mem_addr))
        else $error("address moved at write open");
    write_width_a: assert property ($fell(mem_we_n) |-> !mem_we_n [*2])
        else $error("write overlap too short");
    data_window_a: assert property ($rose(mem_we_n) |-> $past(mem_dq_oe, 2) && mem_dq_oe ##1 $stable(mem_addr))
        else $error("write data or address window short");
    no_clash_a: assert property ($rose(mem_dq_oe) |-> $past(mem_oe_n, 2) && mem_oe_n)
        else $error("host drives while memory may drive");
    read_strobe_a: assert property ($fell(mem_oe_n) |-> (mem_we_n && !mem_cs_n && !mem_dq_oe) [*3])
        else $error("read strobe too short");
    ready_pulse_a: assert property (req_ready |-> $past(req_valid) ##1 !req_ready)
        else $error("ready not a single pulse");
    rdata_pulse_a: assert property (rd_valid |-> mem_cs_n ##1 !rd_valid)
        else $error("read result not a single pulse");
endmodule : sram_host_checker

bind sram_host sram_host_checker #(.AW(AW)) i_chk (.ref_clk(ref_clk), .srst(srst),
    .req_valid(req_valid), .req_ready(req_ready), .rd_valid(rd_valid), .mem_addr(mem_addr),
    .mem_cs_n(mem_cs_n), .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n), .mem_dq_oe(mem_dq_oe));

/* File: bench/byte_sram_model.sv */
`timescale 1ns/10ps
// ==========================================================
// behavioural byte memory on the far side of the pins
module byte_sram_model (
    // strobes and address
    input wire logic        cs_n,
    input wire logic        we_n,
    input wire logic        oe_n,
    input wire logic [10:0] addr,
    // data pins
    input wire logic [7:0]  dq_in,
    output logic     [7:0]  dq_out
);
    logic [7:0] mem [2048];
    logic [7:0] last_q = 8'h3c;
    logic       dq_drv = 1'b0;
    logic       rd_on;
    logic       wr_open;
    // fill with a known pattern
    initial for (int i = 0; i < 2048; i++) mem[i] = ~i[7:0];
    // drive only when selected, write strobe high, gate low
    assign rd_on = !cs_n && we_n && !oe_n;
    // drive starts late and stops after a float delay
    always @(rd_on) dq_drv <= #10 rd_on;
    // old byte lingers after an address move
    always @(addr, dq_drv) last_q <= #10 mem[addr];
    // released pins show the inverse of the last byte
    assign dq_out = dq_drv ? last_q : ~last_q;
    // byte stored at the close of the select and write overlap
    assign wr_open = !cs_n && !we_n;
    always @(negedge wr_open) mem[addr] <= dq_in;
endmodule : byte_sram_model

/* File: bench/test_sram_host.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD t=%0t got %h exp %h", $time, g, e); end end
// ==========================================================
// self-checking bench for the host sequencer
module test_sram_host;
    typedef struct { logic [10:0] a; logic [7:0] d; } row_t;
    logic        ref_clk   = 1'b0;
    logic        srst      = 1'b1;
    logic        req_valid = 1'b0;
    logic        req_write = 1'b0;
    logic [10:0] req_addr  = 11'h000;
    logic [7:0]  req_wdata = 8'h00;
    logic        req_ready, rd_valid, mem_cs_n, mem_we_n, mem_oe_n, mem_dq_oe;
    logic [7:0]  rd_data, mem_dq_o, dq_out, dq_wire;
    logic [10:0] mem_addr;
    int          mismatches = 0;
    int          n_compared = 0;
    row_t        rows [4] = '{'{11'h000, 8'ha5}, '{11'h7ff, 8'h5a},
                              '{11'h123, 8'h00}, '{11'h456, 8'hff}};
    // host drives the wire when enabled, memory otherwise
    assign dq_wire = mem_dq_oe ? mem_dq_o : dq_out;
    sram_host i_dut (.ref_clk(ref_clk), .srst(srst), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data),
        .mem_addr(mem_addr), .mem_cs_n(mem_cs_n), .mem_we_n(mem_we_n),
        .mem_oe_n(mem_oe_n), .mem_dq_o(mem_dq_o), .mem_dq_oe(mem_dq_oe),
        .mem_dq_i(dq_wire));
    byte_sram_model i_mem (.cs_n(mem_cs_n), .we_n(mem_we_n), .oe_n(mem_oe_n),
        .addr(mem_addr), .dq_in(dq_wire), .dq_out(dq_out));
    // 25 MHz clock
    initial forever #20 ref_clk = ~ref_clk;
    // verdict and end of run
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    // one request; a read result is compared with d
    task automatic op(input logic w, input logic [10:0] a, input logic [7:0] d);
        int n;
        n = 0;
        {req_valid, req_write, req_addr, req_wdata} = {1'b1, w, a, d};
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (req_ready !== 1'b1 && n < 50);
        req_valid = 1'b0;
        `CHK(req_ready, 1'b1)
        n = 0;
        while (!w && rd_valid !== 1'b1 && n < 50) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (!w) `CHK(rd_valid, 1'b1)
        if (!w) `CHK(rd_data, d)
        // let an edge pass before the next request
        @(posedge ref_clk);
        #1;
    endtask : op
    // hang guard
    initial begin
        #100000;
        mismatches++;
        test_done;
    end
    // main sequence
    initial begin
        repeat (16) @(posedge ref_clk);
        #1 srst = 1'b0;
        `CHK({mem_cs_n, mem_we_n, mem_oe_n, mem_dq_oe, req_ready, rd_valid}, 6'h38)
        `CHK(mem_addr, 11'h000)
        foreach (rows[i]) op(1'b1, rows[i].a, rows[i].d);
        foreach (rows[i]) op(1'b0, rows[i].a, rows[i].d);
        // overwrite top address then read it straight back
        op(1'b1, 11'h7ff, 8'h3c);
        op(1'b0, 11'h7ff, 8'h3c);
        // reset before the write strobe opens leaves memory alone
        {req_valid, req_write, req_addr, req_wdata} = {1'b1, 1'b1, 11'h123, 8'hee};
        @(posedge ref_clk);
        #1 srst = 1'b1;
        req_valid = 1'b0;
        @(posedge ref_clk);
        #1 srst = 1'b0;
        `CHK({mem_cs_n, mem_we_n, mem_oe_n, mem_dq_oe, req_ready, rd_valid}, 6'h38)
        op(1'b0, 11'h123, 8'h00);
        test_done;
    end
endmodule : test_sram_host
